/* File: build_cfg_pkg.sv */
// constants for the build feature summary readout
`default_nettype none
package build_cfg_pkg;
   // ----------------------------------------------------------------
   // field positions within the 32-bit summary word
   // ----------------------------------------------------------------
   localparam int unsigned WORD_W = 32;
   localparam int unsigned POS_DUAL_CORE = 31;
   localparam int unsigned POS_DUAL_INV_CLK = 30;
   localparam int unsigned POS_ICACHE_ABSENT = 29;
   localparam int unsigned POS_DCACHE_ABSENT = 28;
   localparam int unsigned POS_A_PROT_LO = 26;
   localparam int unsigned POS_B_PROT_LO = 24;
   localparam int unsigned POS_BE_FETCH_ABSENT = 23;
   localparam int unsigned POS_FLOAT_ABSENT = 22;
   localparam int unsigned POS_PROT_UNIT_ABSENT = 21;
   localparam int unsigned POS_REGION_COUNT = 20;
   localparam int unsigned POS_BREAK_LO = 17;
   localparam int unsigned POS_WATCH_LO = 14;
   localparam int unsigned POS_A_PORT_ABSENT = 13;
   localparam int unsigned POS_B0_PORT_ABSENT = 12;
   localparam int unsigned POS_B1_PORT_ABSENT = 11;
   localparam int unsigned POS_LMEM_ADDR_PARITY = 10;
   localparam int unsigned POS_SLAVE_ABSENT = 9;
   localparam int unsigned POS_ICACHE_PROT_LO = 7;
   localparam int unsigned POS_DCACHE_PROT_LO = 5;
   localparam int unsigned POS_ERR_CACHE_ABSENT = 4;
   localparam int unsigned POS_SYS_BUS_PARITY = 3;
   localparam int unsigned RSVD_W = 3;
   localparam int unsigned CNT_W = 3;

   // ----------------------------------------------------------------
   // protection scheme encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_PARITY = 2'h1;
   localparam logic [1:0] PROT_ECC32 = 2'h2;
   localparam logic [1:0] PROT_ECC64 = 2'h3;

   // ----------------------------------------------------------------
   // coprocessor address of the summary register
   // ----------------------------------------------------------------
   localparam logic [3:0] CP_NUM = 4'hf;
   localparam logic [3:0] CP_CRN = 4'hf;
   localparam logic [3:0] CP_CRM = 4'h2;
   localparam logic [2:0] CP_OP1 = 3'h0;
   localparam logic [2:0] CP_OP2 = 3'h1;
   localparam logic [WORD_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: build_opts_if.sv */
// carrier between the option holder and the word packer
`default_nettype none
interface build_opts_if;
   logic dual_core;
   logic redundant_copy_inverted_clock;
   logic instruction_cache_absent;
   logic data_cache_absent;
   logic [1:0] a_port_protection_scheme;
   logic [1:0] b_port_protection_scheme;
   logic big_endian_fetch_absent;
   logic float_unit_absent;
   logic protection_unit_absent;
   logic protection_region_count;
   logic [2:0] break_minus_one;
   logic [2:0] watch_minus_one;
   logic a_port_absent;
   logic b0_port_absent;
   logic b1_port_absent;
   logic local_memory_address_parity_present;
   logic slave_port_absent;
   logic [1:0] instruction_cache_protection;
   logic [1:0] data_cache_protection;
   logic corrected_error_cache_absent;
   logic system_bus_parity_present;
   logic [31:0] word;
   modport src (
      output dual_core, redundant_copy_inverted_clock,
      output instruction_cache_absent, data_cache_absent,
      output a_port_protection_scheme, b_port_protection_scheme,
      output big_endian_fetch_absent, float_unit_absent,
      output protection_unit_absent, protection_region_count,
      output break_minus_one, watch_minus_one,
      output a_port_absent, b0_port_absent, b1_port_absent,
      output local_memory_address_parity_present, slave_port_absent,
      output instruction_cache_protection, data_cache_protection,
      output corrected_error_cache_absent, system_bus_parity_present,
      input word
   );
   modport packer (
      input dual_core, redundant_copy_inverted_clock,
      input instruction_cache_absent, data_cache_absent,
      input a_port_protection_scheme, b_port_protection_scheme,
      input big_endian_fetch_absent, float_unit_absent,
      input protection_unit_absent, protection_region_count,
      input break_minus_one, watch_minus_one,
      input a_port_absent, b0_port_absent, b1_port_absent,
      input local_memory_address_parity_present, slave_port_absent,
      input instruction_cache_protection, data_cache_protection,
      input corrected_error_cache_absent, system_bus_parity_present,
      output word
   );
endinterface
`default_nettype wire

/* File: build_word_packer.sv */
// packs build option fields into the summary word
`default_nettype none
module build_word_packer (
   build_opts_if.packer opts // option fields in, packed word out
);
   // ----------------------------------------------------------------
   // word assembly
   // ----------------------------------------------------------------
   // region count is masked when no protection unit exists, and cache
   // schemes are masked when the cache is absent, so a bad parameter
   // set can never report a region count or cache scheme that is not there
   always_comb begin
      opts.word = build_cfg_pkg::DATA_ZERO;
      opts.word[build_cfg_pkg::POS_DUAL_CORE] = opts.dual_core;
      opts.word[build_cfg_pkg::POS_DUAL_INV_CLK] =
         opts.redundant_copy_inverted_clock;
      opts.word[build_cfg_pkg::POS_ICACHE_ABSENT] =
         opts.instruction_cache_absent;
      opts.word[build_cfg_pkg::POS_DCACHE_ABSENT] = opts.data_cache_absent;
      opts.word[build_cfg_pkg::POS_A_PROT_LO +: 2] =
         opts.a_port_protection_scheme;
      opts.word[build_cfg_pkg::POS_B_PROT_LO +: 2] =
         opts.b_port_protection_scheme;
      opts.word[build_cfg_pkg::POS_BE_FETCH_ABSENT] =
         opts.big_endian_fetch_absent;
      opts.word[build_cfg_pkg::POS_FLOAT_ABSENT] = opts.float_unit_absent;
      opts.word[build_cfg_pkg::POS_PROT_UNIT_ABSENT] =
         opts.protection_unit_absent;
      opts.word[build_cfg_pkg::POS_REGION_COUNT] =
         opts.protection_region_count & ~opts.protection_unit_absent;
      opts.word[build_cfg_pkg::POS_BREAK_LO +: 3] = opts.break_minus_one;
      opts.word[build_cfg_pkg::POS_WATCH_LO +: 3] = opts.watch_minus_one;
      opts.word[build_cfg_pkg::POS_A_PORT_ABSENT] = opts.a_port_absent;
      opts.word[build_cfg_pkg::POS_B0_PORT_ABSENT] = opts.b0_port_absent;
      opts.word[build_cfg_pkg::POS_B1_PORT_ABSENT] = opts.b1_port_absent;
      opts.word[build_cfg_pkg::POS_LMEM_ADDR_PARITY] =
         opts.local_memory_address_parity_present;
      opts.word[build_cfg_pkg::POS_SLAVE_ABSENT] = opts.slave_port_absent;
      opts.word[build_cfg_pkg::POS_ICACHE_PROT_LO +: 2] =
         opts.instruction_cache_absent ? build_cfg_pkg::PROT_NONE
                                       : opts.instruction_cache_protection;
      opts.word[build_cfg_pkg::POS_DCACHE_PROT_LO +: 2] =
         opts.data_cache_absent ? build_cfg_pkg::PROT_NONE
                                : opts.data_cache_protection;
      opts.word[build_cfg_pkg::POS_ERR_CACHE_ABSENT] =
         opts.corrected_error_cache_absent;
      opts.word[build_cfg_pkg::POS_SYS_BUS_PARITY] =
         opts.system_bus_parity_present;
   end
endmodule
`default_nettype wire

/* File: build_config_readout.sv */
// build feature summary register with its coprocessor read port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
module build_config_readout #(
   parameter bit DUAL_CORE = 1'b0,
   parameter bit DUAL_INV_CLK = 1'b0,
   parameter bit HAS_ICACHE = 1'b1,
   parameter bit HAS_DCACHE = 1'b1,
   parameter logic [1:0] A_PROT = 2'h0,
   parameter logic [1:0] B_PROT = 2'h0,
   parameter bit HAS_BE_FETCH = 1'b1,
   parameter bit HAS_FLOAT = 1'b0,
   parameter bit HAS_PROT_UNIT = 1'b1,
   parameter bit TWELVE_REGIONS = 1'b0,
   parameter int unsigned BREAKPOINTS = 6,
   parameter int unsigned WATCHPOINTS = 2,
   parameter bit HAS_A_PORT = 1'b1,
   parameter bit HAS_B0_PORT = 1'b1,
   parameter bit HAS_B1_PORT = 1'b1,
   parameter bit HAS_LMEM_PARITY = 1'b0,
   parameter bit HAS_SLAVE = 1'b1,
   parameter logic [1:0] ICACHE_PROT = 2'h0,
   parameter logic [1:0] DCACHE_PROT = 2'h0,
   parameter bit HAS_ERR_CACHE = 1'b1,
   parameter bit HAS_BUS_PARITY = 1'b0
) (
   input wire logic i_ref_clk, // core clock
   input wire logic i_rst_b, // synchronous reset, active low
   input wire logic i_cp_req, // coprocessor access strobe
   input wire logic i_cp_write, // 1 = write, 0 = read
   input wire logic i_cp_priv, // access made from privileged mode
   input wire logic [3:0] i_cp_num, // coprocessor number
   input wire logic [2:0] i_cp_op1, // first opcode
   input wire logic [3:0] i_cp_crn, // primary register
   input wire logic [3:0] i_cp_crm, // secondary register
   input wire logic [2:0] i_cp_op2, // second opcode
   output logic o_cp_done, // read answered, data valid
   output logic o_cp_undef, // access refused
   output logic [31:0] o_cp_rdata // read data
);
   // ----------------------------------------------------------------
   // option fields, fixed at elaboration
   // ----------------------------------------------------------------
   localparam logic [2:0] BRK_M1 = 3'(BREAKPOINTS - 1);
   localparam logic [2:0] WCH_M1 = 3'(WATCHPOINTS - 1);

   build_opts_if opts ();
   logic [31:0] summary_word;

   // every field is a tie-off, so no clock or reset can disturb it
   assign opts.dual_core = DUAL_CORE;
   assign opts.redundant_copy_inverted_clock = DUAL_INV_CLK;
   assign opts.instruction_cache_absent = ~HAS_ICACHE;
   assign opts.data_cache_absent = ~HAS_DCACHE;
   assign opts.a_port_protection_scheme = A_PROT;
   assign opts.b_port_protection_scheme = B_PROT;
   assign opts.big_endian_fetch_absent = ~HAS_BE_FETCH;
   assign opts.float_unit_absent = ~HAS_FLOAT;
   assign opts.protection_unit_absent = ~HAS_PROT_UNIT;
   assign opts.protection_region_count = TWELVE_REGIONS;
   assign opts.break_minus_one = BRK_M1;
   assign opts.watch_minus_one = WCH_M1;
   assign opts.a_port_absent = ~HAS_A_PORT;
   assign opts.b0_port_absent = ~HAS_B0_PORT;
   assign opts.b1_port_absent = ~HAS_B1_PORT;
   assign opts.local_memory_address_parity_present = HAS_LMEM_PARITY;
   assign opts.slave_port_absent = ~HAS_SLAVE;
   assign opts.instruction_cache_protection = ICACHE_PROT;
   assign opts.data_cache_protection = DCACHE_PROT;
   assign opts.corrected_error_cache_absent = ~HAS_ERR_CACHE;
   assign opts.system_bus_parity_present = HAS_BUS_PARITY;
   assign summary_word = opts.word;

   // masking of dependent fields lives in the packer
   build_word_packer u_packer (
      .opts(opts)
   );

   // ----------------------------------------------------------------
   // access decode
   // ----------------------------------------------------------------
   function automatic logic addr_hit(input logic [3:0] num,
                                     input logic [2:0] op1,
                                     input logic [3:0] crn,
                                     input logic [3:0] crm,
                                     input logic [2:0] op2);
      addr_hit = (num == build_cfg_pkg::CP_NUM) &&
                 (op1 == build_cfg_pkg::CP_OP1) &&
                 (crn == build_cfg_pkg::CP_CRN) &&
                 (crm == build_cfg_pkg::CP_CRM) &&
                 (op2 == build_cfg_pkg::CP_OP2);
   endfunction

   logic hit;
   logic ok_read;
   // only a privileged read of the one address is honoured; a write
   // or a user-mode access to it is refused rather than silently dropped
   assign hit = addr_hit(i_cp_num, i_cp_op1, i_cp_crn, i_cp_crm,
                         i_cp_op2);
   assign ok_read = i_cp_req && hit && !i_cp_write && i_cp_priv;

   // ----------------------------------------------------------------
   // answer registers
   // ----------------------------------------------------------------
   // done pulses one cycle after an accepted read
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_cp_done <= 1'b0;
      end else begin
         o_cp_done <= ok_read;
      end
   end

   // refusal pulse for writes or user-mode hits on this address
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_cp_undef <= 1'b0;
      end else begin
         o_cp_undef <= i_cp_req && hit && !ok_read;
      end
   end

   // data held until the next accepted read, not zeroed between reads;
   // only reset returns it to zero
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_cp_rdata <= build_cfg_pkg::DATA_ZERO;
      end else if (ok_read) begin
         o_cp_rdata <= summary_word;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_read_req;
      i_cp_req && hit && !i_cp_write && i_cp_priv;
   endsequence

   sequence s_bad_req;
      i_cp_req && hit && (i_cp_write || !i_cp_priv);
   endsequence

   property p_read_answer;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_read_req |=> o_cp_done && !o_cp_undef &&
                     (o_cp_rdata == summary_word);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("privileged read not answered with summary");

   property p_refuse;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_bad_req |=> o_cp_undef && !o_cp_done;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("write or user access not refused");

   property p_data_stable;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !ok_read |=> $stable(o_cp_rdata);
   endproperty
   a_data_stable: assert property (p_data_stable)
      else $error("read data changed without a read");

   property p_const_word;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      s_read_req ##1 s_read_req |=> $stable(o_cp_rdata);
   endproperty
   a_const_word: assert property (p_const_word)
      else $error("summary word differs between reads");

   property p_reserved_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_cp_done |-> o_cp_rdata[build_cfg_pkg::RSVD_W-1:0] == 3'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits not zero");

   property p_region_masked;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_cp_done && o_cp_rdata[build_cfg_pkg::POS_PROT_UNIT_ABSENT] |->
         !o_cp_rdata[build_cfg_pkg::POS_REGION_COUNT];
   endproperty
   a_region_masked: assert property (p_region_masked)
      else $error("region count set without protection unit");

   property p_icache_masked;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_cp_done && o_cp_rdata[build_cfg_pkg::POS_ICACHE_ABSENT] |->
         o_cp_rdata[build_cfg_pkg::POS_ICACHE_PROT_LO +: 2] == 2'h0;
   endproperty
   a_icache_masked: assert property (p_icache_masked)
      else $error("icache scheme reported without icache");

   property p_dcache_masked;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_cp_done && o_cp_rdata[build_cfg_pkg::POS_DCACHE_ABSENT] |->
         o_cp_rdata[build_cfg_pkg::POS_DCACHE_PROT_LO +: 2] == 2'h0;
   endproperty
   a_dcache_masked: assert property (p_dcache_masked)
      else $error("dcache scheme reported without dcache");

   property p_counts;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_cp_done |->
         o_cp_rdata[build_cfg_pkg::POS_BREAK_LO +: 3] == BRK_M1 &&
         o_cp_rdata[build_cfg_pkg::POS_WATCH_LO +: 3] == WCH_M1;
   endproperty
   a_counts: assert property (p_counts)
      else $error("break or watch count field wrong");

   property p_absent_bits;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_cp_done |->
         o_cp_rdata[build_cfg_pkg::POS_FLOAT_ABSENT] == !HAS_FLOAT &&
         o_cp_rdata[build_cfg_pkg::POS_SLAVE_ABSENT] == !HAS_SLAVE &&
         o_cp_rdata[build_cfg_pkg::POS_A_PORT_ABSENT] == !HAS_A_PORT &&
         o_cp_rdata[build_cfg_pkg::POS_B_PROT_LO +: 2] == B_PROT;
   endproperty
   a_absent_bits: assert property (p_absent_bits)
      else $error("absent flag polarity or port scheme wrong");

   property p_quiet;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      !i_cp_req |=> !o_cp_done && !o_cp_undef;
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("answer without a request");
endmodule
`default_nettype wire

/* File: build_config_readout_tb.sv */
// self-checking bench for the build feature summary readout
`default_nettype none
module build_config_readout_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // settings, expected word and port signals
   // ----------------------------------------------------------------
   localparam int T_DRV = 10; // inputs move this long after the edge
   localparam int MAX_CYC = 2000; // run needs about 100 cycles
   // five overrides aim at the masking paths: instruction_cache_absent (scheme 11
   // masked), dcache=10, no prot unit (twelve regions masked); the
   // rest default: float absent, brk 6, wch 2, ports and slave present
   localparam logic [31:0] EXP_WORD = {1'b0, 1'b0, 1'b1, 1'b0, 2'h0,
      2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h5, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0,
      1'b0, 2'h0, 2'h2, 1'b0, 1'b0, 3'h0};
   typedef struct {logic undef; logic [31:0] word;} note_t;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic req = 1'b0;
   logic wr = 1'b0;
   logic priv = 1'b0;
   logic [3:0] num = 4'h0;
   logic [2:0] op1 = 3'h0;
   logic [3:0] crn = 4'h0;
   logic [3:0] crm = 4'h0;
   logic [2:0] op2 = 3'h0;
   logic done;
   logic undef;
   logic [31:0] rdata;
   logic [31:0] last_rd = 32'h0000_0000;
   note_t notes[$];
   note_t cur;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   int unsigned seed_val;

   build_config_readout #(.HAS_ICACHE(1'b0), .ICACHE_PROT(2'h3),
      .DCACHE_PROT(2'h2), .HAS_PROT_UNIT(1'b0), .TWELVE_REGIONS(1'b1)
   ) dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cp_req(req),
      .i_cp_write(wr), .i_cp_priv(priv), .i_cp_num(num), .i_cp_op1(op1),
      .i_cp_crn(crn), .i_cp_crm(crm), .i_cp_op2(op2), .o_cp_done(done),
      .o_cp_undef(undef), .o_cp_rdata(rdata));

   // free-running 10 MHz clock
   always #50 i_ref_clk = ~i_ref_clk;

   // ----------------------------------------------------------------
   // comparison, verdict and drive tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // field by field, so a miss names the field at fault
   task automatic check_word(input logic [31:0] w, input logic [31:0] e);
      chk("dual bits", w[31:30], e[31:30]);
      chk("cache absent", w[29:28], e[29:28]);
      chk("a scheme", w[27:26], e[27:26]);
      chk("b scheme", w[25:24], e[25:24]);
      chk("be fetch", w[23], e[23]);
      chk("float", w[22], e[22]);
      chk("prot unit", w[21], e[21]);
      chk("regions", w[20], e[20]);
      chk("breaks", w[19:17], e[19:17]);
      chk("watches", w[16:14], e[16:14]);
      chk("ports absent", w[13:11], e[13:11]);
      chk("addr parity", w[10], e[10]);
      chk("slave", w[9], e[9]);
      chk("icache scheme", w[8:7], e[8:7]);
      chk("dcache scheme", w[6:5], e[6:5]);
      chk("err cache", w[4], e[4]);
      chk("bus parity", w[3], e[3]);
      chk("reserved", w[2:0], e[2:0]);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one access per cycle; a miss disturbs one address field at random
   task automatic drive(input logic w, input logic p, input logic hit);
      note_t n;
      int f;
      f = $urandom_range(0, 4);
      req = 1'b1;
      wr = w;
      priv = p;
      num = build_cfg_pkg::CP_NUM;
      op1 = build_cfg_pkg::CP_OP1;
      crn = build_cfg_pkg::CP_CRN;
      crm = build_cfg_pkg::CP_CRM;
      op2 = build_cfg_pkg::CP_OP2;
      if (!hit) begin
         case (f)
            0: num = num ^ 4'($urandom_range(1, 15));
            1: op1 = op1 ^ 3'($urandom_range(1, 7));
            2: crn = crn ^ 4'($urandom_range(1, 15));
            3: crm = crm ^ 4'($urandom_range(1, 15));
            default: op2 = op2 ^ 3'($urandom_range(1, 7));
         endcase
      end else begin
         n.undef = w | ~p;
         if (!n.undef) begin
            last_rd = EXP_WORD;
         end
         n.word = last_rd;
         notes.push_back(n);
      end
      @(posedge i_ref_clk);
      #T_DRV;
   endtask

   // idle cycles keep the qualifiers moving to show they are ignored
   task automatic idle(input int n);
      repeat (n) begin
         req = 1'b0;
         wr = 1'($urandom);
         priv = 1'($urandom);
         @(posedge i_ref_clk);
         #T_DRV;
      end
      chk("pending answers", notes.size(), 0);
   endtask

   // ----------------------------------------------------------------
   // monitor: every answer consumes the oldest note
   // ----------------------------------------------------------------
   // sampled on the falling edge, so registered outputs have settled
   always @(negedge i_ref_clk) begin
      if (done === 1'b1 || undef === 1'b1) begin
         if (notes.size() == 0) begin
            chk("unasked answer", 32'h1, 32'h0);
         end else begin
            cur = notes.pop_front();
            chk("undef", undef, cur.undef);
            chk("done", done, !cur.undef);
            check_word(rdata, cur.word);
         end
      end
   end

   // hang guard
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == MAX_CYC) begin
         err_total++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed_val = $urandom(91);
      repeat (20) @(posedge i_ref_clk);
      #T_DRV;
      chk("reset outputs", {30'h0, done, undef}, 32'h0);
      chk("reset rdata", rdata, 32'h0);
      i_rst_b = 1'b1;
      idle(1);
      $display("test reset done");
      repeat (4) drive(1'b0, 1'b1, 1'b1);
      idle(3);
      $display("test back to back reads done");
      drive(1'b1, 1'b1, 1'b1);
      drive(1'b0, 1'b0, 1'b1);
      drive(1'b1, 1'b0, 1'b1);
      drive(1'b0, 1'b1, 1'b1);
      drive(1'b1, 1'b1, 1'b1);
      idle(3);
      $display("test refusals done");
      for (int i = 0; i < 12; i++) begin
         drive(1'($urandom), 1'($urandom), 1'b0);
      end
      idle(3);
      $display("test address misses done");
      for (int i = 0; i < 40; i++) begin
         drive(1'($urandom), 1'($urandom), $urandom_range(0, 3) != 0);
      end
      idle(3);
      $display("test random mix done");
      i_rst_b = 1'b0;
      idle(2);
      chk("rdata after reset", rdata, 32'h0);
      last_rd = 32'h0000_0000;
      i_rst_b = 1'b1;
      idle(1);
      drive(1'b1, 1'b1, 1'b1);
      drive(1'b0, 1'b1, 1'b1);
      idle(3);
      $display("test second reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
